// ==== tb/dac_latch_reset_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_latch_reset_control_test;
    import dlr_pkg::*;
    localparam int VW = CHANNELS * DATA_W;
    logic clk = 1'b0, rst_n = 1'b0, ld_n = 1'b0, hw_n = 1'b1, cs_n = 1'b1, wr_n = 1'b1;
    logic sel = 1'b0, ext_n = 1'b1, gpioIn, gpioOut, gpioOe, gpioSense, busyOut, busyOe, aMode;
    logic [4:0] addr = 5'h00;
    logic [DATA_W-1:0] dataIn = 14'h0000;
    logic [VW-1:0] dacCode, expCode = '0;
    int fail_count = 0, n_compared = 0, cycles = 0;
    dlr_host_pins i_dlr_host_pins (.gpioOe(gpioOe), .ext_n(ext_n), .gpioIn(gpioIn));
    dlr_control i_dlr_control (.clk(clk), .rst_n(rst_n), .latchLoad_n(ld_n), .hwReset_n(hw_n),
        .chipSel_n(cs_n), .write_n(wr_n), .dataIn(dataIn), .reg_addr_bit0(addr[0]),
        .reg_addr_bit1(addr[1]), .reg_addr_bit2(addr[2]), .reg_addr_bit3(addr[3]),
        .reg_addr_bit4(addr[4]), .reset_level_select(sel), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioSense(gpioSense), .busyOut(busyOut),
        .busyOe(busyOe), .dacCode(dacCode), .asyncMode(aMode));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic chk(input logic [VW-1:0] seen, input logic [VW-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [DATA_W-1:0] d);
        addr = a;
        dataIn = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(3);
        wr_n = 1'b1;
        step(3);
        chk(busyOe, (a >= ADDR_DATA_BASE) && (a < ADDR_DATA_BASE + 5'(CHANNELS)));
        cs_n = 1'b1;
        step(12);
        chk(busyOe, 1'b0);
    endtask
    task automatic t_latch();
        chk(aMode, 1'b1);
        chk(dacCode, expCode);
        wr(ADDR_DATA_BASE + 5'h07, 14'h3FFF);
        expCode[7*DATA_W +: DATA_W] = 14'h3FFF;
        chk(dacCode, expCode);
        wr(5'h1F, 14'h1234);
        chk(dacCode, expCode);
        ld_n = 1'b1;
        step(4);
        wr(ADDR_DATA_BASE + 5'h03, 14'h0ABC);
        chk(dacCode, expCode);
        ld_n = 1'b0;
        step(4);
        expCode[3*DATA_W +: DATA_W] = 14'h0ABC;
        chk(dacCode, expCode);
    endtask
    task automatic t_gpio();
        wr(ADDR_GPIO, 14'h0000);
        chk({gpioOe, gpioSense}, 2'h2);
        wr(ADDR_GPIO, 14'h0001);
        chk({gpioOe, gpioSense}, 2'h1);
        ext_n = 1'b0;
        step(4);
        chk(gpioSense, 1'b0);
        ext_n = 1'b1;
    endtask
    task automatic t_hwrst(input logic s);
        sel = s;
        // Chip select stays high for the whole reset pulse.
        hw_n = 1'b0;
        step(6);
        hw_n = 1'b1;
        step(4);
        chk(dacCode, {CHANNELS{s ? RESET_CODE_HIGH : RESET_CODE_LOW}});
    endtask
    task automatic t_strap_sync();
        // Latch-load held high across a fresh reset selects synchronous update.
        ld_n = 1'b1;
        rst_n = 1'b0;
        step(6);
        rst_n = 1'b1;
        step(6);
        chk(aMode, 1'b0);
        chk(dacCode, '0);
        wr(ADDR_DATA_BASE, 14'h1555);
        chk(dacCode, '0);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        step(6);
        rst_n = 1'b1;
        step(6);
        t_latch();
        t_gpio();
        t_hwrst(1'b1);
        t_hwrst(1'b0);
        t_strap_sync();
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== tb/dlr_control_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlr_control_chk (
    // Watched ports.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hwReset_n,
    input wire logic latchLoad_n,
    input wire logic reset_level_select,
    input wire logic gpioIn,
    input wire logic gpioOut,
    input wire logic gpioSense,
    input wire logic busyOut,
    input wire logic busyOe,
    input wire logic [dlr_pkg::CHANNELS*dlr_pkg::DATA_W-1:0] dacCode
);
    import dlr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_hw(sel);
        !hwReset_n && reset_level_select == sel;
    endsequence
    sequence s_run;
        busyOe [*8] ##1 busyOe ##1 busyOe ##1 !busyOe;
    endsequence
    a_drain_only: assert property (!gpioOut && !busyOut)
        else $error("pin driven high");
    a_reset_zero: assert property (disable iff (1'b0) !rst_n |=> dacCode == '0)
        else $error("code not cleared");
    a_hw_high: assert property (s_hw(1'b1) [*5] |=> dacCode == {CHANNELS{RESET_CODE_HIGH}})
        else $error("high reset code");
    a_hw_low: assert property (s_hw(1'b0) [*5] |=> dacCode == {CHANNELS{RESET_CODE_LOW}})
        else $error("low reset code");
    a_latch_hold: assert property ((latchLoad_n && hwReset_n) [*5] |=> $stable(dacCode))
        else $error("latch moved");
    a_busy_span: assert property ($rose(busyOe) |-> s_run)
        else $error("busy length");
    a_sense_high: assert property (gpioIn [*4] |=> gpioSense)
        else $error("sense high");
    a_sense_low: assert property (!gpioIn [*4] |=> !gpioSense)
        else $error("sense low");
endmodule
bind dlr_control dlr_control_chk i_dlr_control_chk (.clk(clk), .rst_n(rst_n),
    .hwReset_n(hwReset_n), .latchLoad_n(latchLoad_n), .reset_level_select(reset_level_select),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioSense(gpioSense), .busyOut(busyOut),
    .busyOe(busyOe), .dacCode(dacCode));
`default_nettype wire

// ==== tb/dlr_host_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module dlr_host_pins (
    // Sinks on the shared line.
    input wire logic gpioOe,
    input wire logic ext_n,
    // Resolved line level.
    output logic gpioIn
);
    // The pull-up gives a high level unless one side sinks the line.
    assign gpioIn = !(gpioOe || !ext_n);
endmodule
`default_nettype wire

// ==== verilog/dlr_control.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Latch-load low makes each output latch transparent to its data register.
// - Converter output changes in the same cycle its latch updates.
// - Hardware reset low restores data registers and outputs to selected level.
// - Five address inputs are decoded to choose the target register.
// - General-purpose pin is open drain: pulls low or releases only.
// - Reset-level select sets the output code after hardware reset; power-on reset always gives the low code.
// - Busy output pulls low while the correction engine runs.
module dlr_control (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host pins.
    input wire logic latchLoad_n,
    input wire logic hwReset_n,
    input wire logic chipSel_n,
    input wire logic write_n,
    input wire logic [dlr_pkg::DATA_W-1:0] dataIn,
    input wire logic reg_addr_bit0,
    input wire logic reg_addr_bit1,
    input wire logic reg_addr_bit2,
    input wire logic reg_addr_bit3,
    input wire logic reg_addr_bit4,
    input wire logic reset_level_select,
    // General-purpose open-drain pin.
    input wire logic gpioIn,
    output logic gpioOut,
    output logic gpioOe,
    output logic gpioSense,
    // Busy open-drain pin.
    output logic busyOut,
    output logic busyOe,
    // Converter codes and mode.
    output logic [dlr_pkg::CHANNELS*dlr_pkg::DATA_W-1:0] dacCode,
    output logic asyncMode
);
    import dlr_pkg::*;

    // Pin synchronisers. The control group is forced idle during reset, while the
    // latch-load pair keeps running so that the mode strap reads the real pin level.
    localparam int SW = 10 + DATA_W;
    localparam logic [SW-1:0] SYNC_IDLE = {5'b11101, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};
    logic [SW-1:0] syncA_reg, syncB_reg;
    logic [SW-1:0] syncA_next, syncB_next;
    logic ldSyncA_reg, ldSyncB_reg;
    logic ldSyncA_next, ldSyncB_next;
    logic ldN, rstPinN, csN, wrN, rsel, gpioS;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;

    always_comb begin
        syncA_next = {hwReset_n, chipSel_n, write_n, reset_level_select, gpioIn,
                      reg_addr_bit4, reg_addr_bit3, reg_addr_bit2, reg_addr_bit1,
                      reg_addr_bit0, dataIn};
        syncB_next = syncA_reg;
        if (!rst_n) begin
            syncA_next = SYNC_IDLE;
            syncB_next = SYNC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        syncA_reg <= syncA_next;
        syncB_reg <= syncB_next;
    end

    // Latch-load synchroniser, deliberately without reset.
    always_comb begin
        ldSyncA_next = latchLoad_n;
        ldSyncB_next = ldSyncA_reg;
    end

    always_ff @(posedge clk) begin
        ldSyncA_reg <= ldSyncA_next;
        ldSyncB_reg <= ldSyncB_next;
    end

    assign ldN = ldSyncB_reg;
    assign rstPinN = syncB_reg[SW-1];
    assign csN = syncB_reg[SW-2];
    assign wrN = syncB_reg[SW-3];
    assign rsel = syncB_reg[SW-4];
    assign gpioS = syncB_reg[SW-5];
    // Address decode from the five address lines.
    assign addr = syncB_reg[SW-6 -: ADDR_W];
    assign din = syncB_reg[DATA_W-1:0];

    function automatic logic [DATA_W-1:0] resetCode(input logic sel);
        resetCode = sel ? RESET_CODE_HIGH : RESET_CODE_LOW;
    endfunction

    // True when the address selects the data register of channel ch.
    function automatic logic isChanAddr(input logic [ADDR_W-1:0] a, input int ch);
        isChanAddr = (a == ADDR_DATA_BASE + ADDR_W'(ch));
    endfunction

    logic [DATA_W-1:0] dataReg [CHANNELS];
    logic [DATA_W-1:0] dataNext [CHANNELS];
    logic [DATA_W-1:0] latchReg [CHANNELS];
    logic [DATA_W-1:0] latchNext [CHANNELS];
    logic gpioDrive_reg, gpioDrive_next;
    logic asyncMode_reg, asyncMode_next;
    logic strapDone_reg, strapDone_next;
    logic [7:0] corrCnt_reg, corrCnt_next;
    logic wrStrobe, wrPrev_reg, wrPrev_next;
    logic anyReset;

    // A write is taken on the rising edge of write_n while selected.
    assign wrStrobe = !wrPrev_reg && wrN && !csN;
    assign anyReset = !rst_n || !rstPinN;

    // Write strobe edge detector; held high in reset so release gives no false edge.
    always_comb begin
        wrPrev_next = wrN;
        if (anyReset) begin
            wrPrev_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        wrPrev_reg <= wrPrev_next;
    end

    // Mode is caught once, from the synchronised latch-load level on the first edge
    // after reset release.
    always_comb begin
        strapDone_next = 1'b1;
        asyncMode_next = asyncMode_reg;
        if (!strapDone_reg) begin
            asyncMode_next = !ldN;
        end
        if (!rst_n) begin
            strapDone_next = 1'b0;
            asyncMode_next = ASYNC_MODE_RESET;
        end
    end

    always_ff @(posedge clk) begin
        strapDone_reg <= strapDone_next;
        asyncMode_reg <= asyncMode_next;
    end

    // Data registers and output latches. The logic reset always restores the low code,
    // which also keeps an unknown select out of the codes on the first reset edge.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            dataNext[i] = dataReg[i];
            latchNext[i] = latchReg[i];
            if (wrStrobe && isChanAddr(addr, i)) begin
                dataNext[i] = din;
            end
            if (!ldN) begin
                latchNext[i] = dataNext[i];
            end
            if (anyReset) begin
                dataNext[i] = resetCode(rst_n && rsel);
                latchNext[i] = resetCode(rst_n && rsel);
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < CHANNELS; i++) begin
            dataReg[i] <= dataNext[i];
            latchReg[i] <= latchNext[i];
        end
    end

    // Writing zero to bit 0 of the pin control register pulls the pin low.
    always_comb begin
        gpioDrive_next = gpioDrive_reg;
        if (wrStrobe && addr == ADDR_GPIO) begin
            gpioDrive_next = !din[0];
        end
        if (anyReset) begin
            gpioDrive_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        gpioDrive_reg <= gpioDrive_next;
    end

    // Each data write starts a correction pass; a later write restarts it.
    // Busy then stands for CORR_CYCLES cycles after the last write.
    always_comb begin
        corrCnt_next = (corrCnt_reg != 8'h00) ? corrCnt_reg - 8'h01 : 8'h00;
        for (int i = 0; i < CHANNELS; i++) begin
            if (wrStrobe && isChanAddr(addr, i)) begin
                corrCnt_next = CORR_CYCLES;
            end
        end
        if (anyReset) begin
            corrCnt_next = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        corrCnt_reg <= corrCnt_next;
    end

    // Outputs follow the latches directly, no extra stage.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            dacCode[i*DATA_W +: DATA_W] = latchReg[i];
        end
    end

    // Open-drain pins only ever drive low.
    assign gpioOut = 1'b0;
    assign gpioOe = gpioDrive_reg;
    assign gpioSense = gpioS;
    assign busyOut = 1'b0;
    assign busyOe = (corrCnt_reg != 8'h00);
    assign asyncMode = asyncMode_reg;
endmodule
`default_nettype wire

// ==== verilog/dlr_pkg.sv ====
package dlr_pkg;
    localparam int CHANNELS = 8;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 5;
    // Address of the first channel data register; channels follow in order.
    localparam logic [4:0] ADDR_DATA_BASE = 5'h08;
    // Address of the general-purpose pin control register.
    localparam logic [4:0] ADDR_GPIO = 5'h01;
    // Reset codes selected by reset_level_select: low gives zero code, high mid-scale.
    localparam logic [13:0] RESET_CODE_LOW = 14'h0000;
    localparam logic [13:0] RESET_CODE_HIGH = 14'h2000;
    localparam logic ASYNC_MODE_RESET = 1'b0;
    // Length of one correction pass in ns, converted to cycles at the clock period.
    localparam int CORR_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [7:0] CORR_CYCLES = 8'((CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
